// File: hw/nae_note_acceptor_mode_escrow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nae_note_acceptor_mode_escrow_ctrl
    import nae_pkg::*;
#(
    parameter int TICK_CYC = NAE_TICK_CYC
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    // Configuration button and bezel
    input  wire logic                    cfg_button_in,
    output logic                         bezel_led_out,
    // Host pins
    input  wire logic [NAE_CHANNELS-1:0] inhibit_in,
    input  wire logic                    escrow_in,
    output logic [NAE_CHANNELS-1:0]      credit_out,
    // Note path
    input  wire nae_note_ev_t            note_ev_in,
    output nae_mech_cmd_t                mech_cmd_out,
    output logic                         out_of_service_out,
    // Key exchange and mode
    input  wire logic                    key_xchg_req_in,
    output logic                         key_xchg_accept_out,
    output logic                         trusted_out,
    output nae_proto_t                   proto_out,
    output logic                         self_reset_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers and tick.
    logic [2:0] btn_sync_ff;
    logic [1:0] esc_sync_ff;
    logic [NAE_CHANNELS-1:0] inh_s1_ff;
    logic [NAE_CHANNELS-1:0] inh_s2_ff;
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic tick;

    always_comb begin
        nxt_div = (div_ff == 32'(TICK_CYC - 1)) ? 32'h0 : div_ff + 32'h1;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            btn_sync_ff <= 3'h0;
            esc_sync_ff <= 2'h0;
            inh_s1_ff   <= '0;
            inh_s2_ff   <= '0;
            div_ff      <= 32'h0;
        end else begin
            btn_sync_ff <= {btn_sync_ff[1:0], cfg_button_in};
            esc_sync_ff <= {esc_sync_ff[0], escrow_in};
            inh_s1_ff   <= inhibit_in;
            inh_s2_ff   <= inh_s1_ff;
            div_ff      <= nxt_div;
        end
    end

    assign tick = (div_ff == 32'h0);
    wire logic btn      = btn_sync_ff[1];
    wire logic btn_rel  = btn_sync_ff[2] && !btn_sync_ff[1];
    wire logic escrow_h = esc_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Button, programming and trusted modes.
    typedef enum logic [2:0] {
        MD_IDLE, MD_LOADING, MD_TRUSTED
    } nae_mode_t;

    nae_mode_t  mode_ff, nxt_mode;
    nae_proto_t proto_ff, nxt_proto;
    logic       rst_pulse_ff, nxt_rst_pulse;
    logic       prog_hold, trust_hold, load_done, trust_end;
    logic       fast_ph, slow_ph;

    nae_tick_timer u_hold_prog (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .arm_in(btn && mode_ff == MD_IDLE),
        .tick_in(tick), .limit_in(NAE_TW'(NAE_PROG_HOLD_MS)), .done_out(prog_hold));
    nae_tick_timer u_hold_trust (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .arm_in(btn && mode_ff == MD_IDLE),
        .tick_in(tick), .limit_in(NAE_TW'(NAE_TRUST_HOLD_MS + 1)), .done_out(trust_hold));
    nae_tick_timer u_load (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .arm_in(mode_ff == MD_LOADING),
        .tick_in(tick), .limit_in(NAE_TW'(NAE_LOAD_MS)), .done_out(load_done));
    nae_tick_timer u_trust (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .arm_in(mode_ff == MD_TRUSTED),
        .tick_in(tick), .limit_in(NAE_TW'(NAE_TRUST_OPEN_MS)), .done_out(trust_end));

    // The flash phase counter is free running on the tick; no need to restart it.
    logic [NAE_TW-1:0] flash_ff, nxt_flash;
    always_comb begin
        nxt_flash = tick ? flash_ff + NAE_TW'(1) : flash_ff;
    end
    assign fast_ph = flash_ff[5];
    assign slow_ph = flash_ff[7];

    // The hold length is judged at release, so a hold past three seconds never
    // also triggers the programming switch.
    logic held2_ff, nxt_held2, held3_ff, nxt_held3;

    always_comb begin
        nxt_mode      = mode_ff;
        nxt_proto     = proto_ff;
        nxt_rst_pulse = 1'b0;
        nxt_held2     = btn ? (held2_ff | prog_hold) : 1'b0;
        nxt_held3     = btn ? (held3_ff | trust_hold) : 1'b0;
        case (mode_ff)
            MD_IDLE: begin
                if (btn_rel && held3_ff) begin
                    nxt_mode = MD_TRUSTED;
                end else if (btn_rel && held2_ff) begin
                    if (proto_ff == NAE_PROTO_CONFIGURED) begin
                        nxt_mode = MD_LOADING;
                    end else begin
                        nxt_proto = NAE_PROTO_CONFIGURED;
                        nxt_rst_pulse = 1'b1;
                    end
                end
            end
            MD_LOADING: begin
                if (load_done) begin
                    nxt_mode      = MD_IDLE;
                    nxt_proto     = NAE_PROTO_SERIAL_PROGRAMMING_PROTOCOL;
                    nxt_rst_pulse = 1'b1;
                end
            end
            MD_TRUSTED: begin
                if (trust_end) begin
                    nxt_mode = MD_IDLE;
                end
            end
            default: nxt_mode = MD_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_ff      <= MD_IDLE;
            proto_ff     <= NAE_PROTO_CONFIGURED;
            rst_pulse_ff <= 1'b0;
            held2_ff     <= 1'b0;
            held3_ff     <= 1'b0;
            flash_ff     <= '0;
        end else begin
            mode_ff      <= nxt_mode;
            proto_ff     <= nxt_proto;
            rst_pulse_ff <= nxt_rst_pulse;
            held2_ff     <= nxt_held2;
            held3_ff     <= nxt_held3;
            flash_ff     <= nxt_flash;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Escrow.
    typedef enum logic [2:0] {
        ES_WAIT, ES_HELD, ES_CLAIMED, ES_STACKING, ES_RETURNING, ES_VEND_END, ES_OOS
    } nae_esc_t;

    nae_esc_t          esc_ff, nxt_esc;
    logic [1:0]        chan_ff, nxt_chan;
    nae_mech_cmd_t     cmd_ff, nxt_cmd;
    logic              credit_go;
    logic              esc_tmo, oos_end, credit_end;
    logic              credit_on_ff, nxt_credit_on;

    nae_tick_timer u_esc (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .arm_in     (esc_ff == ES_HELD),
        .tick_in    (tick),
        .limit_in   (NAE_TW'(NAE_ESCROW_MS)),
        .done_out   (esc_tmo)
    );
    nae_tick_timer u_oos (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .arm_in     (esc_ff == ES_OOS),
        .tick_in    (tick),
        .limit_in   (NAE_TW'(NAE_OOS_MS)),
        .done_out   (oos_end)
    );
    nae_tick_timer u_credit (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .arm_in     (credit_on_ff),
        .tick_in    (tick),
        .limit_in   (NAE_TW'(NAE_CREDIT_MS)),
        .done_out   (credit_end)
    );

    always_comb begin
        nxt_esc   = esc_ff;
        nxt_chan  = chan_ff;
        nxt_cmd   = '0;
        credit_go = 1'b0;
        case (esc_ff)
            ES_WAIT: begin
                if (note_ev_in.validated) begin
                    nxt_esc   = ES_HELD;
                    nxt_chan  = note_ev_in.channel;
                    credit_go = 1'b1;
                end
            end
            ES_HELD: begin
                if (note_ev_in.removed) begin
                    nxt_esc = ES_OOS;
                end else if (inh_s2_ff[chan_ff]) begin
                    nxt_esc = ES_RETURNING;
                    nxt_cmd.give_back = 1'b1;
                end else if (escrow_h) begin
                    nxt_esc = ES_CLAIMED;
                end else if (esc_tmo) begin
                    nxt_esc = ES_RETURNING;
                    nxt_cmd.give_back = 1'b1;
                end
            end
            ES_CLAIMED: begin
                nxt_esc = ES_STACKING;
                nxt_cmd.stack = 1'b1;
            end
            ES_STACKING: begin
                if (note_ev_in.stacked_done) begin
                    nxt_esc   = ES_VEND_END;
                    credit_go = 1'b1;
                end
            end
            ES_RETURNING: begin
                if (note_ev_in.returned_done) begin
                    nxt_esc = ES_WAIT;
                end
            end
            ES_VEND_END: begin
                if (!escrow_h && !credit_on_ff) begin
                    nxt_esc = ES_WAIT;
                end
            end
            ES_OOS: begin
                if (oos_end) begin
                    nxt_esc = ES_WAIT;
                end
            end
            default: nxt_esc = ES_WAIT;
        endcase
        nxt_credit_on = credit_go | (credit_on_ff & !credit_end);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            esc_ff       <= ES_WAIT;
            chan_ff      <= NAE_RST_CHAN;
            cmd_ff       <= '0;
            credit_on_ff <= 1'b0;
        end else begin
            esc_ff       <= nxt_esc;
            chan_ff      <= nxt_chan;
            cmd_ff       <= nxt_cmd;
            credit_on_ff <= nxt_credit_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.
    logic [NAE_CHANNELS-1:0] credit_ff;
    logic                    led_ff, nxt_led;

    always_comb begin
        case (mode_ff)
            MD_LOADING: nxt_led = fast_ph;
            MD_TRUSTED: nxt_led = slow_ph;
            default:    nxt_led = held2_ff | held3_ff;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            credit_ff <= '0;
            led_ff    <= 1'b0;
        end else begin
            credit_ff <= credit_on_ff ? (NAE_CHANNELS'(1) << chan_ff) : '0;
            led_ff    <= nxt_led;
        end
    end

    assign credit_out          = credit_ff;
    assign bezel_led_out       = led_ff;
    assign mech_cmd_out        = cmd_ff;
    assign out_of_service_out  = (esc_ff == ES_OOS);
    assign trusted_out         = (mode_ff == MD_TRUSTED);
    assign key_xchg_accept_out = key_xchg_req_in && (mode_ff == MD_TRUSTED);
    assign proto_out           = proto_ff;
    assign self_reset_out      = rst_pulse_ff;
endmodule : nae_note_acceptor_mode_escrow_ctrl
`default_nettype wire

// File: hw/nae_pkg.sv
package nae_pkg;

    localparam int          NAE_CLK_HZ        = 250_000_000;
    localparam int          NAE_TICK_US       = 1000;
    localparam int          NAE_TICK_CYC      = NAE_CLK_HZ / 1_000_000 * NAE_TICK_US;
    localparam int          NAE_PROG_HOLD_MS  = 2000;
    localparam int          NAE_TRUST_HOLD_MS = 3000;
    localparam int          NAE_TRUST_OPEN_MS = 30_000;
    localparam int          NAE_ESCROW_MS     = 30_000;
    localparam int          NAE_CREDIT_MS     = 100;
    localparam int          NAE_OOS_MS        = 45_000;
    localparam int          NAE_LOAD_MS       = 500;
    localparam int          NAE_FAST_HALF_MS  = 62;
    localparam int          NAE_SLOW_HALF_MS  = 250;
    localparam int          NAE_CHANNELS      = 4;
    localparam int          NAE_TW            = 16;
    localparam logic [1:0]  NAE_RST_CHAN      = 2'h0;

    typedef enum logic [1:0] {
        NAE_PROTO_CONFIGURED,
        NAE_PROTO_SERIAL_PROGRAMMING_PROTOCOL
    } nae_proto_t;

    // Note path events from the validation engine, one-cycle pulses.
    typedef struct packed {
        logic       inserted;
        logic       validated;
        logic       removed;
        logic       stacked_done;
        logic       returned_done;
        logic [1:0] channel;
    } nae_note_ev_t;

    // Commands to the transport mechanism, one-cycle pulses.
    typedef struct packed {
        logic stack;
        logic give_back;
    } nae_mech_cmd_t;

endpackage : nae_pkg

// File: hw/nae_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts ticks while armed; clears the moment arming drops.
module nae_tick_timer
    import nae_pkg::*;
#(
    parameter int W = NAE_TW
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // Control
    input  wire logic         arm_in,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] limit_in,
    // Status
    output logic              done_out
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    always_comb begin
        nxt_count = count_ff;
        if (!arm_in) begin
            nxt_count = '0;
        end else if (tick_in && count_ff != limit_in) begin
            nxt_count = count_ff + W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign done_out = arm_in && (count_ff == limit_in);
endmodule : nae_tick_timer
`default_nettype wire

// File: verification/nae_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module nae_ctrl_props
    import nae_pkg::*;
#(
    parameter int TICK_CYC = NAE_TICK_CYC
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    // Watched ports
    input  wire logic                    cfg_button_in,
    input  wire logic                    escrow_in,
    input  wire logic [NAE_CHANNELS-1:0] credit_out,
    input  wire nae_mech_cmd_t           mech_cmd_out,
    input  wire logic                    key_xchg_req_in,
    input  wire logic                    key_xchg_accept_out,
    input  wire logic                    trusted_out,
    input  wire nae_proto_t              proto_out,
    input  wire logic                    self_reset_out
);
    // A slack of a few ticks allows for the tick phase at the start of a count.
    // Windows are 64 bits wide because thirty seconds of a full-rate clock overflow 32 bits.
    localparam longint CR_LO = longint'(NAE_CREDIT_MS - 2) * TICK_CYC;
    localparam longint CR_HI = longint'(NAE_CREDIT_MS + 2) * TICK_CYC;
    localparam longint TR_LO = longint'(NAE_TRUST_OPEN_MS - 2) * TICK_CYC;
    localparam longint TR_HI = longint'(NAE_TRUST_OPEN_MS + 2) * TICK_CYC;
    logic [63:0] cr_cnt_ff;
    logic [63:0] nxt_cr_cnt;
    logic [63:0] tr_cnt_ff;
    logic [63:0] nxt_tr_cnt;
    always_comb begin
        nxt_cr_cnt = (sys_rst_in || !(|credit_out)) ? 64'h0 : cr_cnt_ff + 64'h1;
        nxt_tr_cnt = (sys_rst_in || !trusted_out) ? 64'h0 : tr_cnt_ff + 64'h1;
    end
    always_ff @(posedge clk_in) begin
        cr_cnt_ff <= nxt_cr_cnt;
        tr_cnt_ff <= nxt_tr_cnt;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_held_before;
        $past(cfg_button_in, 8);
    endsequence
    sequence s_claim_seen;
        $past(escrow_in, 3);
    endsequence
    property p_accept; key_xchg_accept_out == (key_xchg_req_in && trusted_out); endproperty
    property p_onehot; $onehot0(credit_out); endproperty
    property p_cmd_excl; !(mech_cmd_out.stack && mech_cmd_out.give_back); endproperty
    property p_stack_claim; mech_cmd_out.stack |-> s_claim_seen; endproperty
    property p_credit_len; $fell(|credit_out) |-> (cr_cnt_ff >= CR_LO && cr_cnt_ff <= CR_HI); endproperty
    property p_rst_pulse; self_reset_out |=> !self_reset_out; endproperty
    property p_proto_cause; $changed(proto_out) |-> (self_reset_out || $past(self_reset_out)); endproperty
    property p_trust_entry; $rose(trusted_out) |-> s_held_before; endproperty
    property p_trust_len; $fell(trusted_out) |-> (tr_cnt_ff >= TR_LO && tr_cnt_ff <= TR_HI); endproperty
    a_accept: assert property (p_accept) else $error("key accepted outside trusted mode");
    a_onehot: assert property (p_onehot) else $error("credit on several channels");
    a_cmd_excl: assert property (p_cmd_excl) else $error("stack and give back together");
    a_stack_claim: assert property (p_stack_claim) else $error("stack without host claim");
    a_credit_len: assert property (p_credit_len) else $error("credit pulse length wrong");
    a_rst_pulse: assert property (p_rst_pulse) else $error("self reset longer than a cycle");
    a_proto_cause: assert property (p_proto_cause) else $error("protocol changed without reset");
    a_trust_entry: assert property (p_trust_entry) else $error("trusted without button hold");
    a_trust_len: assert property (p_trust_len) else $error("trusted window length wrong");
endmodule : nae_ctrl_props
bind nae_note_acceptor_mode_escrow_ctrl nae_ctrl_props #(.TICK_CYC(TICK_CYC)) nae_ctrl_props_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_button_in(cfg_button_in), .escrow_in(escrow_in),
    .credit_out(credit_out), .mech_cmd_out(mech_cmd_out), .key_xchg_req_in(key_xchg_req_in),
    .key_xchg_accept_out(key_xchg_accept_out), .trusted_out(trusted_out), .proto_out(proto_out),
    .self_reset_out(self_reset_out));
`default_nettype wire

// File: verification/nae_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Mode 0 idles and clears, 1 claims the note, 2 aborts through inhibit.
module nae_host_model
    import nae_pkg::*;
(
    // Clock and bench control
    input  wire logic                    clk_in,
    input  wire logic [1:0]              mode_in,
    // Device pins
    input  wire logic [NAE_CHANNELS-1:0] credit_in,
    output logic [NAE_CHANNELS-1:0]      inhibit_out,
    output logic                         escrow_out
);
    logic [NAE_CHANNELS-1:0] last_cr;
    int                      falls;
    initial begin
        inhibit_out = '0;
        escrow_out = 1'b0;
        last_cr = '0;
        falls = 0;
    end
    always @(posedge clk_in) begin
        #1;
        if (mode_in == 2'h0) begin
            inhibit_out = '0;
            escrow_out = 1'b0;
            falls = 0;
        end else if (last_cr != '0 && credit_in == '0) begin
            falls = falls + 1;
            if (mode_in == 2'h1) begin
                escrow_out = (falls == 1);
            end
            if (mode_in == 2'h2) begin
                inhibit_out = last_cr;
            end
        end
        last_cr = credit_in;
    end
endmodule : nae_host_model
`default_nettype wire

// File: verification/nae_note_acceptor_mode_escrow_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module nae_note_acceptor_mode_escrow_ctrl_test;
    import nae_pkg::*;
    // One clock per tick keeps the 30 s windows inside the run length.
    localparam int LIMIT = 90_000;
    logic                    clk_in, sys_rst_in, cfg_button_in, bezel_led_out, escrow_in;
    logic                    out_of_service_out, key_xchg_req_in, key_xchg_accept_out;
    logic                    trusted_out, self_reset_out;
    logic [NAE_CHANNELS-1:0] inhibit_in, credit_out;
    logic [1:0]              host_mode;
    nae_note_ev_t            note_ev_in;
    nae_mech_cmd_t           mech_cmd_out;
    nae_proto_t              proto_out;
    int                      err_total = 0, num_checks = 0, cyc_cnt = 0;
    nae_note_acceptor_mode_escrow_ctrl #(.TICK_CYC(1)) nae_note_acceptor_mode_escrow_ctrl_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_button_in(cfg_button_in),
        .bezel_led_out(bezel_led_out), .inhibit_in(inhibit_in), .escrow_in(escrow_in),
        .credit_out(credit_out), .note_ev_in(note_ev_in), .mech_cmd_out(mech_cmd_out),
        .out_of_service_out(out_of_service_out), .key_xchg_req_in(key_xchg_req_in),
        .key_xchg_accept_out(key_xchg_accept_out), .trusted_out(trusted_out),
        .proto_out(proto_out), .self_reset_out(self_reset_out));
    nae_host_model nae_host_model_i (.clk_in(clk_in), .mode_in(host_mode), .credit_in(credit_out),
        .inhibit_out(inhibit_in), .escrow_out(escrow_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic chk(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask : chk4
    task automatic ev(input nae_note_ev_t e);
        note_ev_in = e;
        step(1);
        note_ev_in = '0;
    endtask : ev
    task automatic wt(input int sel, input int lim, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            case (sel)
                0: hit = (mech_cmd_out.stack === 1'b1);
                1: hit = (mech_cmd_out.give_back === 1'b1);
                2: hit = (credit_out !== 4'h0);
                3: hit = (self_reset_out === 1'b1);
                default: hit = (trusted_out === 1'b1);
            endcase
            if (!hit) begin
                step(1);
                n++;
            end
        end
    endtask : wt
    ////////////////////////////////////////////////////////////////////////
    task automatic t_prog;
        int   n;
        int   tog;
        logic l;
        cfg_button_in = 1'b1;
        step(2100);
        chk(bezel_led_out, 1'b1, "led dark while held");
        cfg_button_in = 1'b0;
        tog = 0;
        l = bezel_led_out;
        repeat (200) begin
            step(1);
            tog += (bezel_led_out !== l);
            l = bezel_led_out;
        end
        chk(tog > 2, 1'b1, "no fast flash while loading");
        wt(3, 700, n);
        chk(n < 700, 1'b1, "no self reset after load");
        step(1);
        chk(proto_out === NAE_PROTO_SERIAL_PROGRAMMING_PROTOCOL, 1'b1, "not programming");
        cfg_button_in = 1'b1;
        step(2100);
        cfg_button_in = 1'b0;
        wt(3, 700, n);
        chk(n < 700, 1'b1, "no self reset on restore");
        step(1);
        chk(proto_out === NAE_PROTO_CONFIGURED, 1'b1, "interface not restored");
    endtask : t_prog
    task automatic t_escrow(input int mode);
        int n;
        host_mode = mode[1:0];
        ev('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h1});
        step(2);
        chk4(credit_out, 4'h2, "first credit");
        ev('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3});
        step(3);
        chk4(credit_out, 4'h2, "second note taken");
        wt(mode == 1 ? 0 : 1, 31000, n);
        if (mode == 1) begin
            chk(n > 80 && n < 400, 1'b1, "stack not after claim");
            ev('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1});
            wt(2, 20, n);
            chk4(credit_out, 4'h2, "final credit");
        end else if (mode == 2) begin
            chk(n > 80 && n < 300, 1'b1, "abort not prompt");
        end else begin
            chk(n > 29940 && n < 30060, 1'b1, "escrow timeout length");
        end
        if (mode != 1) begin
            ev('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1});
        end
        step(150);
        host_mode = 2'h0;
        step(5);
    endtask : t_escrow
    task automatic t_trusted;
        int   n;
        int   tog;
        logic l;
        cfg_button_in = 1'b1;
        step(3100);
        cfg_button_in = 1'b0;
        wt(4, 20, n);
        chk(n < 20, 1'b1, "no trusted entry");
        key_xchg_req_in = 1'b1;
        #1;
        chk(key_xchg_accept_out, 1'b1, "key refused in trusted");
        step(1);
        key_xchg_req_in = 1'b0;
        n = 0;
        tog = 0;
        l = bezel_led_out;
        while (trusted_out === 1'b1 && n < 30100) begin
            step(1);
            n++;
            tog += (bezel_led_out !== l);
            l = bezel_led_out;
        end
        chk(n > 29950 && n < 30050, 1'b1, "trusted window length");
        chk(tog > 50, 1'b1, "no steady flash");
        key_xchg_req_in = 1'b1;
        #1;
        chk(key_xchg_accept_out, 1'b0, "key accepted after close");
        step(1);
        key_xchg_req_in = 1'b0;
    endtask : t_trusted
    // Runs last: the out-of-service time is longer than the rest of the run may take.
    task automatic t_oos;
        ev('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2});
        step(3);
        chk4(credit_out, 4'h4, "credit before removal");
        ev('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2});
        step(1);
        chk(out_of_service_out, 1'b1, "not out of service after removal");
        step(200);
        ev('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0});
        step(3);
        chk4(credit_out, 4'h0, "credit while out of service");
        step(1000);
        chk(out_of_service_out, 1'b1, "service back too early");
    endtask : t_oos
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT) begin
            err_total++;
            report_and_stop;
        end
    end
    initial begin
        sys_rst_in = 1'b1;
        cfg_button_in = 1'b0;
        key_xchg_req_in = 1'b0;
        note_ev_in = '0;
        host_mode = 2'h0;
        step(12);
        sys_rst_in = 1'b0;
        step(4);
        t_prog;
        t_escrow(1);
        t_escrow(2);
        t_escrow(0);
        t_trusted;
        t_oos;
        report_and_stop;
    end
endmodule : nae_note_acceptor_mode_escrow_ctrl_test
`default_nettype wire
